/* File: sim/daisy_chain_serial_framer_tb_top.sv */
`timescale 1ns/1ps
module daisy_chain_serial_framer_tb_top;
  import dcsf_pkg::*;
  logic sys_clk, rst_b, ce, sclk, serial_in, serial_out, rd_load, rx_valid, rx_bcast;
  logic [47:0] rd_data, rx_data;
  logic [4:0] dev_addr;
  int n_fail, num_checks, n_valid, v0;
  logic exp_q[$];

  dcsf_framer dcsf_framer_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .sclk(sclk),
    .serial_in(serial_in), .serial_out(serial_out), .rd_data(rd_data), .rd_load(rd_load),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_bcast(rx_bcast), .dev_addr(dev_addr));
  dcsf_host_model dcsf_host_model_inst (.sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) if (rx_valid === 1'b1) n_valid++;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Expected output stream: start, words with check bits, end run
  task automatic exp_frame(input logic [15:0] ws[$], input int bad_at);
    exp_q.push_back(1'b0);
    foreach (ws[w]) begin
      for (int i = 15; i >= 0; i--) exp_q.push_back(ws[w][i]);
      exp_q.push_back((w == bad_at) ? ws[w][0] : ~ws[w][0]);
    end
    repeat (18) exp_q.push_back(1'b1);
  endtask : exp_frame

  // Aligns on the first low bit seen at the output
  task automatic chk_out(input string what, input int nwait);
    int k;
    int m;
    k = 0;
    m = 0;
    repeat (nwait) @(posedge sclk);
    while (k < dcsf_host_model_inst.out_q.size() && dcsf_host_model_inst.out_q[k] !== 1'b0)
      k++;
    foreach (exp_q[j])
      if (k + j >= dcsf_host_model_inst.out_q.size() ||
          dcsf_host_model_inst.out_q[k + j] !== exp_q[j]) m++;
    check(what, m, 0);
    exp_q.delete();
    dcsf_host_model_inst.out_q.delete();
  endtask : chk_out

  task automatic t_chip();
    dcsf_host_model_inst.send_frame('{16'hA505}, -1);
    exp_frame('{16'hA506}, -1);
    chk_out("chip_fwd", 100);
    check("dev_addr", dev_addr, 5'h05);
  endtask : t_chip

  task automatic t_dev();
    v0 = n_valid;
    dcsf_host_model_inst.send_frame('{16'hC200, 16'h1111, 16'h2222, 16'h3333, 16'hABCD,
      16'h0F0F, 16'h8002}, -1);
    exp_frame('{16'hC200, 16'h1111, 16'h2222, 16'h3333}, -1);
    chk_out("dev_cut", 100);
    check("dev_data", rx_data, 48'hABCD0F0F8002);
    check("dev_bcast", rx_bcast, 1'b0);
    check("dev_valid", n_valid - v0, 1);
  endtask : t_dev

  task automatic t_bcast();
    v0 = n_valid;
    dcsf_host_model_inst.send_frame('{16'hB100, 16'h5555, 16'h6666, 16'h7777}, -1);
    dcsf_host_model_inst.send_frame('{16'hB100, 16'h0123, 16'h4567, 16'h89AB}, -1);
    exp_frame('{16'hB100, 16'h5555, 16'h6666, 16'h7777}, -1);
    chk_out("bcast_fwd", 100);
    check("bcast_valid", n_valid - v0, 2);
    check("bcast_data", rx_data, 48'h0123456789AB);
    check("bcast_flag", rx_bcast, 1'b1);
  endtask : t_bcast

  task automatic t_bad();
    v0 = n_valid;
    repeat (5) @(posedge sclk);
    dcsf_host_model_inst.send_frame('{16'hB100, 16'hFFF0, 16'h1234, 16'h5678}, 2);
    exp_frame('{16'hB100, 16'hFFF0, 16'h1234, 16'h5678}, 2);
    chk_out("bad_fwd", 100);
    check("bad_valid", n_valid - v0, 0);
    check("bad_data", rx_data, 48'h0123456789AB);
    // Unknown command: forwarded unchanged, nothing applied
    v0 = n_valid;
    dcsf_host_model_inst.send_frame('{16'h1200, 16'h0001, 16'h0002, 16'h0003}, -1);
    exp_frame('{16'h1200, 16'h0001, 16'h0002, 16'h0003}, -1);
    chk_out("other_fwd", 100);
    check("other_valid", n_valid - v0, 0);
    check("other_addr", dev_addr, 5'h05);
  endtask : t_bad

  task automatic t_read();
    @(negedge sys_clk);
    rd_data = 48'h123456789ABC;
    rd_load = 1'b1;
    @(negedge sys_clk);
    rd_load = 1'b0;
    repeat (8) @(posedge sclk);
    dcsf_host_model_inst.send_frame('{16'hD300, 16'h1111, 16'h2222, 16'h3330}, -1);
    exp_frame('{16'hD300, 16'h1111, 16'h2222, 16'h3330, 16'h1234, 16'h5678, 16'h9ABC}, -1);
    chk_out("read_insert", 160);
  endtask : t_read

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("CHECK FAILED watchdog expected 0 seen 1");
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    rd_load = 1'b0;
    rd_data = 48'h0;
    // Long enough for two link clock edges
    repeat (14) @(negedge sys_clk);
    check("rst_out", serial_out, 1'b1);
    rst_b = 1'b1;
    repeat (10) @(posedge sclk);
    check("rst_valid", rx_valid, 1'b0);
    check("rst_addr", dev_addr, 5'h00);
    check("rst_data", rx_data, 48'h0);
    dcsf_host_model_inst.out_q.delete();
    t_chip();
    t_dev();
    t_bcast();
    t_bad();
    t_read();
    finish_test();
  end
endmodule : daisy_chain_serial_framer_tb_top

/* File: sim/dcsf_host_model.sv */
`timescale 1ns/1ps
module dcsf_host_model (
  output logic sclk,
  output logic serial_in,
  input wire logic serial_out
);
  logic out_q[$];

  initial begin
    sclk = 1'b0;
    serial_in = 1'b1;
    #7;
    forever #32 sclk = ~sclk;
  end

  always @(posedge sclk) out_q.push_back(serial_out);

  // Moves on falling edges, stable at rising
  task automatic send_bit(input logic b);
    @(negedge sclk);
    serial_in = b;
  endtask : send_bit

  task automatic send_frame(input logic [15:0] ws[$], input int bad_at);
    send_bit(1'b0);
    foreach (ws[w]) begin
      for (int i = 15; i >= 0; i--) send_bit(ws[w][i]);
      send_bit((w == bad_at) ? ws[w][0] : ~ws[w][0]);
    end
    repeat (18) send_bit(1'b1);
  endtask : send_frame
endmodule : dcsf_host_model

/* File: verilog/dcsf_delay_line.sv */
`timescale 1ns/1ps
module dcsf_delay_line
  import dcsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic [dcsf_pkg::LINE_LEN-1:0] line_nxt,
  input wire logic long_tap,
  output logic [dcsf_pkg::LINE_LEN-1:0] line_r,
  output logic dout_r
);
  // Idle-high fill so the output reads as idle after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_r <= '1;
    end else if (en) begin
      line_r <= line_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_r <= 1'b1;
    end else if (en) begin
      dout_r <= long_tap ? line_nxt[LONG_TAP] : line_nxt[SHORT_TAP];
    end
  end
endmodule : dcsf_delay_line

/* File: verilog/dcsf_framer.sv */
`timescale 1ns/1ps
module dcsf_framer
  import dcsf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic [dcsf_pkg::PIX_BITS-1:0] rd_data,
  input wire logic rd_load,
  output logic [dcsf_pkg::PIX_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_bcast,
  output logic [dcsf_pkg::ADDR_W-1:0] dev_addr
);
  import dcsf_pkg::*;

  function automatic logic [PIX_BITS-1:0] strip_group(input logic [GROUP_BITS-1:0] g);
    strip_group = {g[50:35], g[33:18], g[16:1]};
  endfunction : strip_group

  function automatic logic [GROUP_BITS-1:0] pack_group(input logic [PIX_BITS-1:0] d);
    pack_group = {d[47:32], ~d[32], d[31:16], ~d[16], d[15:0], ~d[0]};
  endfunction : pack_group

  // Readback hand-off, sys_clk side
  logic [PIX_BITS-1:0] rd_hold_r;
  logic rd_tgl_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_hold_r <= '0;
      rd_tgl_r <= 1'b0;
    end else if (ce && rd_load) begin
      rd_hold_r <= rd_data;
      rd_tgl_r <= ~rd_tgl_r;
    end
  end

  // Link side, sclk domain
  logic ce_l1_r, ce_l2_r;
  logic sin_1_r, sin_2_r;
  logic rdt_1_r, rdt_2_r, rdt_3_r;
  logic [PIX_BITS-1:0] rd_link_r;
  dcsf_state_e state_r;
  dcsf_kind_e kind_r;
  logic [4:0] cnt_r;
  logic [4:0] run_r;
  logic [WORD_BITS-1:0] sh_r;
  logic bad_r;
  logic long_r;
  logic [ADDR_W-1:0] addr_r;
  logic [PIX_BITS-1:0] grp_r;
  logic grp_bcast_r;
  logic grp_have_r;
  logic done_tgl_r;
  logic [LINE_LEN-1:0] line_r;
  logic [LINE_LEN-1:0] line_nxt;
  logic long_nxt;

  logic en_l;
  logic bit_in;
  logic start, word_done, word_bad, hdr_done, end_hit;
  logic [WORD_BITS-1:0] word_now;
  logic [DATA_BITS-1:0] data16;
  logic [7:0] cmd_now;
  logic [ADDR_W-1:0] idx_p1;
  logic chip_ok, ins_read, drop_dev, take_grp;

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      ce_l1_r <= 1'b0;
      ce_l2_r <= 1'b0;
    end else begin
      ce_l1_r <= ce;
      ce_l2_r <= ce_l1_r;
    end
  end
  assign en_l = ce_l2_r;

  // Two-stage pin capture, rising edge only
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      sin_1_r <= 1'b1;
      sin_2_r <= 1'b1;
    end else if (en_l) begin
      sin_1_r <= serial_in;
      sin_2_r <= sin_1_r;
    end
  end
  assign bit_in = sin_2_r;

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      rdt_1_r <= 1'b0;
      rdt_2_r <= 1'b0;
      rdt_3_r <= 1'b0;
      rd_link_r <= '0;
    end else if (en_l) begin
      rdt_1_r <= rd_tgl_r;
      rdt_2_r <= rdt_1_r;
      rdt_3_r <= rdt_2_r;
      if (rdt_2_r != rdt_3_r) begin
        rd_link_r <= rd_hold_r;
      end
    end
  end

  assign word_now = {sh_r[WORD_BITS-2:0], bit_in};
  assign data16 = word_now[WORD_BITS-1:1];
  assign cmd_now = data16[CMD_MSB:CMD_LSB];
  assign idx_p1 = data16[IDX_MSB:0] + 5'h01;
  // Frame opens on a low bit after a high one
  assign start = (state_r == ST_IDLE) && !bit_in && sh_r[0];
  assign word_done = (state_r != ST_IDLE) && (cnt_r == WORD_LAST);
  // All-ones word may be the end pattern, not a fault
  assign word_bad = word_done && (word_now[0] == word_now[1]) && !(&word_now);
  assign hdr_done = (state_r == ST_HEAD) && word_done;
  // End run tested only at a word boundary, so a high last check bit cannot end it early
  assign end_hit = (state_r != ST_IDLE) && bit_in && (cnt_r == 5'h00) &&
    (run_r >= END_RUN - 5'h01);
  assign chip_ok = hdr_done && !word_bad && (cmd_now == CMD_CHIP_INDEX);
  assign ins_read = end_hit && !bad_r && (kind_r == K_READ) && !long_r;
  assign drop_dev = end_hit && !bad_r && (kind_r == K_DEV);
  assign take_grp = end_hit && !bad_r && ((kind_r == K_DEV) || (kind_r == K_BCAST));

  always_comb begin
    line_nxt = {line_r[LINE_LEN-2:0], bit_in};
    long_nxt = long_r;
    if (chip_ok) begin
      line_nxt[WORD_BITS-1:0] = {data16[DATA_BITS-1:IDX_MSB+1], idx_p1, ~idx_p1[0]};
    end
    if (drop_dev) begin
      line_nxt[GRP_HI:GRP_LO] = '1;
    end
    if (ins_read) begin
      line_nxt[LONG_TAP:INS_LO] = line_nxt[GRP_HI:GRP_LO];
      line_nxt[GRP_HI:GRP_LO] = pack_group(rd_link_r);
      long_nxt = 1'b1;
    end else if (long_r && (&line_nxt[LONG_TAP:GRP_LO])) begin
      long_nxt = 1'b0;
    end
  end

  dcsf_delay_line u_line (
    .clk(sclk),
    .rst_b(rst_b),
    .en(en_l),
    .line_nxt(line_nxt),
    .long_tap(long_nxt),
    .line_r(line_r),
    .dout_r(serial_out)
  );

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      long_r <= 1'b0;
      sh_r <= '1;
    end else if (en_l) begin
      long_r <= long_nxt;
      sh_r <= word_now;
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= 5'h00;
    end else if (en_l) begin
      if (!bit_in) begin
        run_r <= 5'h00;
      end else if (run_r != END_RUN) begin
        run_r <= run_r + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
    end else if (en_l) begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_HEAD;
            cnt_r <= 5'h00;
          end
        end
        ST_HEAD, ST_BODY: begin
          cnt_r <= word_done ? 5'h00 : cnt_r + 5'h01;
          if (end_hit) begin
            state_r <= ST_IDLE;
          end else if (hdr_done) begin
            state_r <= ST_BODY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      kind_r <= K_OTHER;
    end else if (en_l && hdr_done) begin
      unique case (cmd_now)
        CMD_CHIP_INDEX: kind_r <= K_CHIP;
        CMD_WRITE_BCAST: kind_r <= K_BCAST;
        CMD_WRITE_DEV: kind_r <= K_DEV;
        CMD_READ: kind_r <= K_READ;
        default: kind_r <= K_OTHER;
      endcase
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      bad_r <= 1'b0;
    end else if (en_l) begin
      if (start) begin
        bad_r <= 1'b0;
      end else if (word_bad) begin
        bad_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= ADDR_RST;
    end else if (en_l && chip_ok) begin
      addr_r <= data16[IDX_MSB:0];
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      grp_r <= '0;
      grp_bcast_r <= 1'b0;
      grp_have_r <= 1'b0;
      done_tgl_r <= 1'b0;
    end else if (en_l && end_hit && !bad_r) begin
      if (take_grp) begin
        grp_r <= strip_group(line_r[GRP_HI-1:GRP_LO-1]);
        grp_bcast_r <= (kind_r == K_BCAST);
      end
      grp_have_r <= take_grp;
      done_tgl_r <= ~done_tgl_r;
    end
  end

  // Frame results, sys_clk side
  logic dt_1_r, dt_2_r, dt_3_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dt_1_r <= 1'b0;
      dt_2_r <= 1'b0;
      dt_3_r <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_bcast <= 1'b0;
      dev_addr <= ADDR_RST;
    end else if (ce) begin
      dt_1_r <= done_tgl_r;
      dt_2_r <= dt_1_r;
      dt_3_r <= dt_2_r;
      rx_valid <= (dt_2_r != dt_3_r) && grp_have_r;
      if (dt_2_r != dt_3_r) begin
        dev_addr <= addr_r;
        if (grp_have_r) begin
          rx_data <= grp_r;
          rx_bcast <= grp_bcast_r;
        end
      end
    end
  end

  // Checks
  chk_end_to_idle: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && end_hit |=> state_r == ST_IDLE)
    else $error("receiver not idle after end run");

  chk_start_header: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && start |=> state_r == ST_HEAD && cnt_r == 5'h00)
    else $error("start bit did not open header");

  chk_dev_group_cut: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && drop_dev |=> &line_r[GRP_HI:GRP_LO])
    else $error("own group still forwarded");

  chk_read_insert_data: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && ins_read |=> long_r && line_r[GRP_HI:GRP_LO] == pack_group(rd_link_r))
    else $error("readback not inserted before end");

  chk_index_forward: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && chip_ok |=> line_r[IDX_MSB+1:1] == addr_r + 5'h01 && line_r[0] != line_r[1])
    else $error("chip index not forwarded incremented");

  chk_bad_no_apply: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && end_hit && bad_r |=> $stable(done_tgl_r) && $stable(grp_r))
    else $error("malformed frame applied");

  chk_bcast_pass: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && end_hit && !bad_r && kind_r == K_BCAST |=>
      line_r[GRP_HI:GRP_LO] == $past(line_r[GRP_HI-1:GRP_LO-1]))
    else $error("broadcast group not forwarded unchanged");

  chk_msb_first_grp: assert property (
    @(posedge sclk) disable iff (!rst_b)
    en_l && take_grp |=>
      grp_r[PIX_BITS-1:PIX_BITS-DATA_BITS] == $past(line_r[GRP_HI-1:GRP_HI-DATA_BITS]))
    else $error("first word not placed in top bits");

  chk_rx_one_pulse: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rx_valid |=> !rx_valid)
    else $error("frame result pulse longer than one cycle");
endmodule : dcsf_framer

/* File: verilog/dcsf_pkg.sv */
// How it works
// - Sample serial input on rising edges only
// - High-to-low transition on input starts a frame
// - First word is command header plus check
// - Then three 17-bit words per chained device
// - Eighteen consecutive ones end frame, receiver idles
// - Start accepted right after previous end pattern
// - Up to 32 devices chained in series
// - Chip index assigns addresses 0x00 to 0x1F
// - Command decides broadcast or per-device data
// - Serial output forwards frames and returns readback
// - Chip index: take index, forward it incremented
// - Per-device write keeps last 51 bits
// - Read inserts own 48 bits before end
// - Words travel most significant bit first
package dcsf_pkg;
  localparam int WORD_BITS = 17;
  localparam int DATA_BITS = 16;
  localparam int PIX_BITS = 48;
  localparam int GROUP_BITS = 51;
  localparam int MAX_DEVS = 32;
  localparam int ADDR_W = 5;
  localparam logic [4:0] END_RUN = 5'h12;
  localparam logic [4:0] WORD_LAST = 5'h10;
  localparam logic [4:0] ADDR_RST = 5'h00;
  // Delay line: group (51) plus end run (18), plus 51 of insertion slack
  localparam int LINE_LEN = 120;
  localparam int SHORT_TAP = 68;
  localparam int LONG_TAP = 119;
  localparam int GRP_LO = 18;
  localparam int GRP_HI = 68;
  localparam int INS_LO = 69;
  // Header field layout
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 8;
  localparam int IDX_MSB = 4;
  localparam logic [7:0] CMD_CHIP_INDEX = 8'hA5;
  localparam logic [7:0] CMD_WRITE_BCAST = 8'hB1;
  localparam logic [7:0] CMD_WRITE_DEV = 8'hC2;
  localparam logic [7:0] CMD_READ = 8'hD3;
  typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_BODY} dcsf_state_e;
  typedef enum logic [2:0] {K_CHIP, K_BCAST, K_DEV, K_READ, K_OTHER} dcsf_kind_e;
endpackage : dcsf_pkg
